//--- design/bawr_pkg.sv
package bawr_pkg;

  // ---------------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] IDX_PORT_LOW   = 8'h1C;
  localparam logic [7:0] IDX_NP_BOT     = 8'h20;
  localparam logic [7:0] IDX_NP_TOP     = 8'h22;
  localparam logic [7:0] IDX_PF_BOT     = 8'h24;
  localparam logic [7:0] IDX_PF_TOP     = 8'h26;
  localparam logic [7:0] IDX_PF_BOT_HI  = 8'h28;
  localparam logic [7:0] IDX_PF_TOP_HI  = 8'h2C;
  localparam logic [7:0] IDX_IO_BOT_HI  = 8'h30;
  localparam logic [7:0] IDX_IO_TOP_HI  = 8'h32;
  localparam logic [7:0] IDX_NONE       = 8'hFF;

  // ---------------------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------------------
  localparam int IDX_LSB      = 2;
  localparam int IDX_W        = 8;
  localparam int WIN_LSB      = 4;
  localparam int WIN_W        = 12;
  localparam int CAP_BIT      = 0;
  localparam int PORT_BOT_LSB = 4;
  localparam int PORT_TOP_LSB = 12;
  localparam int PORT_NIB_W   = 4;
  localparam int PORT_MIRROR  = 8;
  localparam int MEM_LOW_W    = 20;
  localparam int PORT_LOW_W   = 12;

  // ---------------------------------------------------------------------------
  // reset values and fill patterns
  // ---------------------------------------------------------------------------
  localparam logic [11:0] RST_NP_BOT    = 12'hFFF;
  localparam logic [11:0] RST_NP_TOP    = 12'h000;
  localparam logic [11:0] RST_PF_BOT    = 12'hFFF;
  localparam logic [11:0] RST_PF_TOP    = 12'h000;
  localparam logic        RST_PF_CAP    = 1'b1;
  localparam logic [31:0] RST_PF_BOT_HI = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_PF_TOP_HI = 32'h0000_0000;
  localparam logic [15:0] RST_IO_BOT_HI = 16'hFFFF;
  localparam logic [15:0] RST_IO_TOP_HI = 16'h0000;
  localparam logic [3:0]  RST_IO_BOT    = 4'hF;
  localparam logic [3:0]  RST_IO_TOP    = 4'h0;
  localparam logic        RST_IO_CAP    = 1'b1;
  localparam logic [19:0] MEM_LOW_ONES  = 20'hF_FFFF;
  localparam logic [11:0] PORT_LOW_ONES = 12'hFFF;

  // ---------------------------------------------------------------------------
  // bus answers
  // ---------------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- design/bawr_win_if.sv
`timescale 1ns/100ps
`default_nettype none

// one address window: assembled bounds, probe address and match
interface bawr_win_if #(parameter int W = 32);
  logic [W-1:0] base;
  logic [W-1:0] limit;
  logic [W-1:0] addr;
  logic         hit;
  modport cmp (input base, input limit, input addr, output hit);
  modport usr (output base, output limit, output addr, input hit);
endinterface

`default_nettype wire

//--- design/bawr_win_cmp.sv
`timescale 1ns/100ps
`default_nettype none

// inclusive range check; a base above the limit matches nothing
module bawr_win_cmp #(
  parameter int W = 32
) (
  bawr_win_if.cmp win
);
  // refuse a window of no width when elaborating
  if (W < 1) begin : g_width_chk
    $error("bawr_win_cmp: width must be positive");
  end

  assign win.hit = (win.addr >= win.base) && (win.addr <= win.limit); // RQ17
endmodule

`default_nettype wire

//--- design/bawr_regs.sv
// How it works
// (RQ1) Non-prefetchable top field, bits 15:4, RW, reset zero, low twenty bits all ones.
// (RQ2) Non-prefetchable bottom and top pair decides non-prefetchable forwarding.
// (RQ3) Prefetchable bottom bit 0 is the wide flag, reset 1; 1 means 64-bit.
// (RQ4) Prefetchable top bit 0 is read-only and mirrors the wide flag.
// (RQ5) Prefetchable bottom field, bits 15:4, RW, reset 0xFFF, 1MB aligned.
// (RQ6) Prefetchable top field, bits 15:4, RW, reset zero, low bits all ones.
// (RQ7) Prefetchable forwarding uses bottom, top and both upper halves together.
// (RQ8) Prefetchable bottom upper word, RW, reset all ones, address bits 63:32.
// (RQ9) Prefetchable top upper word, RW, reset zero, upper 32 limit bits.
// (RQ10) With the prefetchable wide flag clear, both upper words ignore writes, read zero.
// (RQ11) Port bottom upper half, RW, reset 0xFFFF, address bits 31:16.
// (RQ12) Port top upper half, RW, reset zero, address bits 31:16.
// (RQ13) With the port wide flag clear, both port upper halves ignore writes, read zero.
// (RQ14) Port wide flag selects 16 or 32-bit decode; top byte mirrors it.
// (RQ15) Non-prefetchable bottom field, bits 15:4, RW, reset 0xFFF, 1MB aligned.
// (RQ16) Reserved low bits of memory registers read zero and drop writes.
// (RQ17) Address hits when within bottom and top inclusive; inverted window matches nothing.
// (RQ18) In 32-bit prefetchable mode the upper 32 window bits count as zero.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module bawr_regs #(
  parameter int ADDR_W = 12
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic [31:0]       np_addr,
  output logic                   np_hit,
  input  wire logic [63:0]       pf_addr,
  output logic                   pf_hit,
  input  wire logic [31:0]       io_addr,
  output logic                   io_hit
);
  // refuse an address bus too narrow for the word index when elaborating
  if (ADDR_W <= bawr_pkg::IDX_LSB + bawr_pkg::IDX_W) begin : g_addr_chk
    $error("bawr_regs: ADDR_W too small");
  end

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [11:0] np_bot_q, np_top_q, pf_bot_q, pf_top_q;
  logic        pf_cap_q, io_cap_q;
  logic [31:0] pf_bot_hi_q, pf_top_hi_q;
  logic [15:0] io_bot_hi_q, io_top_hi_q;
  logic [3:0]  io_bot_q, io_top_q;
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic        aw_hold_q, w_hold_q;
  logic [7:0]  widx_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q, rresp_q;
  logic        np_hit_q, pf_hit_q, io_hit_q;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // word index of a byte address, or none when upper bits are set
  function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] a);
    if (a[ADDR_W-1:bawr_pkg::IDX_LSB+bawr_pkg::IDX_W] != '0) begin
      return bawr_pkg::IDX_NONE;
    end
    return a[bawr_pkg::IDX_LSB +: bawr_pkg::IDX_W];
  endfunction

  function automatic logic mapped(input logic [7:0] i);
    case (i)
      bawr_pkg::IDX_PORT_LOW, bawr_pkg::IDX_NP_BOT, bawr_pkg::IDX_NP_TOP,
      bawr_pkg::IDX_PF_BOT, bawr_pkg::IDX_PF_TOP, bawr_pkg::IDX_PF_BOT_HI,
      bawr_pkg::IDX_PF_TOP_HI, bawr_pkg::IDX_IO_BOT_HI,
      bawr_pkg::IDX_IO_TOP_HI: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // byte-lane merge of new write data over the current image
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[b*8 +: 8] = n[b*8 +: 8];
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // read images; reserved bits and locked upper halves show zero
  // ---------------------------------------------------------------------------
  wire [31:0] img_np_bot = {16'h0000, np_bot_q, 4'h0};                      // RQ15 RQ16
  wire [31:0] img_np_top = {16'h0000, np_top_q, 4'h0};                      // RQ1 RQ16
  wire [31:0] img_pf_bot = {16'h0000, pf_bot_q, 3'h0, pf_cap_q};            // RQ3 RQ5
  wire [31:0] img_pf_top = {16'h0000, pf_top_q, 3'h0, pf_cap_q};            // RQ4 RQ6
  wire [31:0] img_port   = {16'h0000, io_top_q, 3'h0, io_cap_q,
                            io_bot_q, 3'h0, io_cap_q};                      // RQ14

  function automatic logic [31:0] img(input logic [7:0] i);
    case (i)
      bawr_pkg::IDX_PORT_LOW:  return img_port;
      bawr_pkg::IDX_NP_BOT:    return img_np_bot;
      bawr_pkg::IDX_NP_TOP:    return img_np_top;
      bawr_pkg::IDX_PF_BOT:    return img_pf_bot;
      bawr_pkg::IDX_PF_TOP:    return img_pf_top;
      bawr_pkg::IDX_PF_BOT_HI: return pf_bot_hi_q;                         // RQ8
      bawr_pkg::IDX_PF_TOP_HI: return pf_top_hi_q;                         // RQ9
      bawr_pkg::IDX_IO_BOT_HI: return {16'h0000, io_bot_hi_q};             // RQ11
      bawr_pkg::IDX_IO_TOP_HI: return {16'h0000, io_top_hi_q};             // RQ12
      default:                 return 32'h0000_0000;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // write channel decode
  // ---------------------------------------------------------------------------
  wire        aw_take = awvalid && awready_q;
  wire        w_take  = wvalid && wready_q;
  wire        ar_take = arvalid && arready_q;
  wire        wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  wire        wr_ok   = wr_fire && mapped(widx_q);
  wire [7:0]  ridx    = idx_of(araddr);
  logic [31:0] wimg;

  // current image merged with the write; a process, so that a change of a
  // register read inside img() re-evaluates it, which a plain assign would miss
  always_comb begin
    wimg = merge(img(widx_q), wdata_q, wstrb_q);
  end

  // write address and data are taken independently, then held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      widx_q    <= bawr_pkg::IDX_NONE;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      awready_q <= awvalid && !awready_q && !aw_hold_q;
      wready_q  <= wvalid && !wready_q && !w_hold_q;
      aw_hold_q <= (aw_hold_q && !wr_fire) || aw_take;
      w_hold_q  <= (w_hold_q && !wr_fire) || w_take;
      if (aw_take) widx_q <= idx_of(awaddr);
      if (w_take) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
    end
  end

  // write response, held until bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= bawr_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= mapped(widx_q) ? bawr_pkg::RESP_OKAY : bawr_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read channel: data captured when the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= bawr_pkg::RESP_OKAY;
    end else begin
      arready_q <= arvalid && !arready_q && !rvalid_q;
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q  <= img(ridx);
        rresp_q  <= mapped(ridx) ? bawr_pkg::RESP_OKAY : bawr_pkg::RESP_SLVERR;
      end else if (rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // memory window registers
  // ---------------------------------------------------------------------------
  wire [11:0] w_win = wimg[bawr_pkg::WIN_LSB +: bawr_pkg::WIN_W];

  // only bits 15:4 and the wide flag store anything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      np_bot_q <= bawr_pkg::RST_NP_BOT;                                     // RQ15
      np_top_q <= bawr_pkg::RST_NP_TOP;                                     // RQ1
      pf_bot_q <= bawr_pkg::RST_PF_BOT;                                     // RQ5
      pf_top_q <= bawr_pkg::RST_PF_TOP;                                     // RQ6
      pf_cap_q <= bawr_pkg::RST_PF_CAP;                                     // RQ3
    end else if (wr_ok) begin
      case (widx_q)
        bawr_pkg::IDX_NP_BOT: np_bot_q <= w_win;                           // RQ15 RQ16
        bawr_pkg::IDX_NP_TOP: np_top_q <= w_win;                           // RQ1 RQ16
        bawr_pkg::IDX_PF_BOT: begin
          pf_bot_q <= w_win;                                               // RQ5
          pf_cap_q <= wimg[bawr_pkg::CAP_BIT];                             // RQ3
        end
        bawr_pkg::IDX_PF_TOP: pf_top_q <= w_win;                           // RQ4 RQ6
        default: ;
      endcase
    end
  end

  // prefetchable upper words; cleared and frozen while the flag is clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pf_bot_hi_q <= bawr_pkg::RST_PF_BOT_HI;                               // RQ8
      pf_top_hi_q <= bawr_pkg::RST_PF_TOP_HI;                               // RQ9
    end else if (!pf_cap_q) begin
      pf_bot_hi_q <= 32'h0000_0000;                                         // RQ10
      pf_top_hi_q <= 32'h0000_0000;                                         // RQ10
    end else if (wr_ok && widx_q == bawr_pkg::IDX_PF_BOT_HI) begin
      pf_bot_hi_q <= wimg;                                                  // RQ8
    end else if (wr_ok && widx_q == bawr_pkg::IDX_PF_TOP_HI) begin
      pf_top_hi_q <= wimg;                                                  // RQ9
    end
  end

  // ---------------------------------------------------------------------------
  // port window registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_bot_q <= bawr_pkg::RST_IO_BOT;
      io_top_q <= bawr_pkg::RST_IO_TOP;
      io_cap_q <= bawr_pkg::RST_IO_CAP;                                     // RQ14
    end else if (wr_ok && widx_q == bawr_pkg::IDX_PORT_LOW) begin
      io_bot_q <= wimg[bawr_pkg::PORT_BOT_LSB +: bawr_pkg::PORT_NIB_W];
      io_top_q <= wimg[bawr_pkg::PORT_TOP_LSB +: bawr_pkg::PORT_NIB_W];
      io_cap_q <= wimg[bawr_pkg::CAP_BIT];                                  // RQ14
    end
  end

  // port upper halves; cleared and frozen while the flag is clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_bot_hi_q <= bawr_pkg::RST_IO_BOT_HI;                               // RQ11
      io_top_hi_q <= bawr_pkg::RST_IO_TOP_HI;                               // RQ12
    end else if (!io_cap_q) begin
      io_bot_hi_q <= 16'h0000;                                              // RQ13
      io_top_hi_q <= 16'h0000;                                              // RQ13
    end else if (wr_ok && widx_q == bawr_pkg::IDX_IO_BOT_HI) begin
      io_bot_hi_q <= wimg[15:0];                                            // RQ11
    end else if (wr_ok && widx_q == bawr_pkg::IDX_IO_TOP_HI) begin
      io_top_hi_q <= wimg[15:0];                                            // RQ12
    end
  end

  // ---------------------------------------------------------------------------
  // window decode
  // ---------------------------------------------------------------------------
  bawr_win_if #(.W(32)) np_win ();
  bawr_win_if #(.W(64)) pf_win ();
  bawr_win_if #(.W(32)) io_win ();

  // assembled bounds; upper halves already read zero in narrow mode
  assign np_win.base  = {np_bot_q, {bawr_pkg::MEM_LOW_W{1'b0}}};            // RQ2
  assign np_win.limit = {np_top_q, bawr_pkg::MEM_LOW_ONES};                 // RQ1 RQ2
  assign np_win.addr  = np_addr;
  assign pf_win.base  = {pf_bot_hi_q, pf_bot_q, {bawr_pkg::MEM_LOW_W{1'b0}}}; // RQ7 RQ18
  assign pf_win.limit = {pf_top_hi_q, pf_top_q, bawr_pkg::MEM_LOW_ONES};    // RQ7 RQ18
  assign pf_win.addr  = pf_addr;
  assign io_win.base  = {io_bot_hi_q, io_bot_q, {bawr_pkg::PORT_LOW_W{1'b0}}};
  assign io_win.limit = {io_top_hi_q, io_top_q, bawr_pkg::PORT_LOW_ONES};
  assign io_win.addr  = io_addr;

  bawr_win_cmp #(.W(32)) u_np_cmp (.win(np_win));
  bawr_win_cmp #(.W(64)) u_pf_cmp (.win(pf_win));
  bawr_win_cmp #(.W(32)) u_io_cmp (.win(io_win));

  // match flags registered one cycle after the probe address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      np_hit_q <= 1'b0;
      pf_hit_q <= 1'b0;
      io_hit_q <= 1'b0;
    end else begin
      np_hit_q <= np_win.hit;                                               // RQ2
      pf_hit_q <= pf_win.hit;                                               // RQ7
      io_hit_q <= io_win.hit;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;
  assign np_hit  = np_hit_q;
  assign pf_hit  = pf_hit_q;
  assign io_hit  = io_hit_q;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_np_top_write: assert property (@(posedge aclk) disable iff (!aresetn) // RQ1
    wr_ok && widx_q == bawr_pkg::IDX_NP_TOP && wstrb_q == 4'hF
    |=> np_top_q == $past(wdata_q[bawr_pkg::WIN_LSB +: bawr_pkg::WIN_W]))
    else $error("non-prefetchable top not written");
  a_np_window_hit: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
    ##1 np_hit_q == ($past(np_addr) >= {$past(np_bot_q), 20'h00000}
                 && $past(np_addr) <= {$past(np_top_q), 20'hFFFFF}))
    else $error("non-prefetchable hit wrong");
  a_pf_top_mirror: assert property (@(posedge aclk) disable iff (!aresetn) // RQ4
    ar_take && ridx == bawr_pkg::IDX_PF_TOP |=> rdata_q[0] == $past(pf_cap_q))
    else $error("prefetchable top flag not mirrored");
  a_pf_high_lock: assert property (@(posedge aclk) disable iff (!aresetn) // RQ10
    !pf_cap_q ##1 !pf_cap_q |-> pf_bot_hi_q == 32'h0 && pf_top_hi_q == 32'h0)
    else $error("prefetchable upper words not zero");
  a_io_high_lock: assert property (@(posedge aclk) disable iff (!aresetn) // RQ13
    !io_cap_q ##1 !io_cap_q |-> io_bot_hi_q == 16'h0 && io_top_hi_q == 16'h0)
    else $error("port upper halves not zero");
  a_io_flag_mirror: assert property (@(posedge aclk) disable iff (!aresetn) // RQ14
    ar_take && ridx == bawr_pkg::IDX_PORT_LOW
    |=> rdata_q[8] == $past(io_cap_q) && rdata_q[0] == $past(io_cap_q))
    else $error("port flag mirror differs");
  a_rsvd_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RQ16
    ar_take && (ridx == bawr_pkg::IDX_NP_BOT || ridx == bawr_pkg::IDX_NP_TOP)
    |=> rdata_q[3:0] == 4'h0)
    else $error("reserved bits not zero");
  a_pf_narrow_miss: assert property (@(posedge aclk) disable iff (!aresetn) // RQ18
    !pf_cap_q && $stable(pf_cap_q) && pf_addr[63:32] != 32'h0 |=> !pf_hit_q)
    else $error("narrow mode matched a high address");
  a_inverted_none: assert property (@(posedge aclk) disable iff (!aresetn) // RQ17
    np_bot_q > np_top_q && $stable(np_bot_q) && $stable(np_top_q) |=> !np_hit_q)
    else $error("inverted window matched");
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    aw_take && w_take |-> ##1 !bvalid_q ##1 bvalid_q)
    else $error("write answer not on time");
endmodule

`default_nettype wire

//--- test/bawr_host.sv
`timescale 1ns/100ps
`default_nettype none

// configuration master on the register bus
module bawr_host (
  input  wire logic        aclk,
  output logic [11:0]      awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [11:0]      araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);

  // bus idle at time zero
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr} = 24'h000000;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
  end

  // one write; each channel is released at the edge that takes it
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] r, output bit ok);
    logic [2:0] s;
    ok = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int i = 0; i < 50 && !ok; i++) begin
      @(negedge aclk);
      s = {awready, wready, bvalid};
      r = bresp;
      @(posedge aclk);
      if (s[2]) awvalid <= 1'b0;
      if (s[1]) wvalid <= 1'b0;
      if (s[0]) begin
        bready <= 1'b0;
        ok = 1'b1;
      end
    end
  endtask

  // one read; rready held until the answer is sampled
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r, output bit ok);
    logic [1:0] s;
    ok = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int i = 0; i < 50 && !ok; i++) begin
      @(negedge aclk);
      s = {arready, rvalid};
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (s[1]) arvalid <= 1'b0;
      if (s[0]) begin
        rready <= 1'b0;
        ok = 1'b1;
      end
    end
  endtask
endmodule

`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic        aclk, aresetn, np_hit, pf_hit, io_hit;
  logic [31:0] np_addr, io_addr;
  logic [63:0] pf_addr;
  int          err_total, comparisons;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;

  bawr_host host_u (
    .aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
  );
  bawr_regs #(.ADDR_W(12)) dut_u (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .np_addr, .np_hit, .pf_addr, .pf_hit, .io_addr, .io_hit
  );

  // 25 MHz clock
  always #20 aclk = ~aclk;

  // counts and final verdict
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bus wrappers; a hung transfer ends the run
  task automatic wrc(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er = bawr_pkg::RESP_OKAY);
    logic [1:0] r;
    bit         ok;
    host_u.wr(a, d, r, ok);
    if (!ok) begin
      err_total++;
      stop_test();
    end else begin
      cmp(r, er);
    end
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input logic [1:0] er = bawr_pkg::RESP_OKAY);
    logic [31:0] d;
    logic [1:0]  r;
    bit          ok;
    host_u.rd(a, d, r, ok);
    if (!ok) begin
      err_total++;
      stop_test();
    end else begin
      cmp({r, d}, {er, e});
    end
  endtask

  // drive the three probes, check the hits two edges later
  task automatic prb(input logic [31:0] n, input logic [63:0] p, input logic [31:0] i,
                     input logic [2:0] e);
    @(posedge aclk);
    np_addr <= n;
    pf_addr <= p;
    io_addr <= i;
    repeat (2) @(posedge aclk);
    #1 cmp({np_hit, pf_hit, io_hit}, e);
  endtask

  task automatic t_reset();
    logic [11:0] a [9] = '{12'h070, 12'h080, 12'h088, 12'h090, 12'h098, 12'h0A0, 12'h0B0,
                           12'h0C0, 12'h0C8};
    logic [31:0] e [9] = '{32'h01F1, 32'hFFF0, 32'h0, 32'hFFF1, 32'h1, 32'hFFFF_FFFF, 32'h0,
                           32'hFFFF, 32'h0};
    for (int k = 0; k < 9; k++) rdc(a[k], e[k]);
    prb(32'hFFF0_0000, 64'h0, 32'h0, 3'h0);
    $display("reset values done");
  endtask

  task automatic t_rsv();
    wrc(12'h088, 32'hFFFF_FFFF);
    rdc(12'h088, 32'hFFF0);
    wrc(12'h098, 32'h0000_FFF0);
    rdc(12'h098, 32'hFFF1);
    wrc(12'h004, 32'h1, bawr_pkg::RESP_SLVERR);
    rdc(12'h004, 32'h0, bawr_pkg::RESP_SLVERR);
    $display("reserved bits done");
  endtask

  task automatic t_win();
    wrc(12'h080, 32'h1230);
    wrc(12'h088, 32'h1240);
    wrc(12'h090, 32'h0011);
    wrc(12'h098, 32'h0020);
    wrc(12'h0A0, 32'h1);
    wrc(12'h0B0, 32'h1);
    wrc(12'h070, 32'h2011);
    wrc(12'h0C0, 32'h3);
    wrc(12'h0C8, 32'h3);
    rdc(12'h070, 32'h2111);
    prb(32'h1230_0000, 64'h1_0010_0000, 32'h0003_1000, 3'h7);
    prb(32'h124F_FFFF, 64'h1_002F_FFFF, 32'h0003_2FFF, 3'h7);
    prb(32'h1250_0000, 64'h0_0010_0000, 32'h0003_3000, 3'h0);
    prb(32'h122F_FFFF, 64'h2_0010_0000, 32'h0002_1000, 3'h0);
    wrc(12'h088, 32'h1220);
    prb(32'h1230_0000, 64'h1_0010_0000, 32'h0003_1000, 3'h3);
    $display("windows done");
  endtask

  task automatic t_cap();
    wrc(12'h090, 32'h0010);
    rdc(12'h098, 32'h0020);
    rdc(12'h0A0, 32'h0);
    wrc(12'h0B0, 32'h1234_5678);
    rdc(12'h0B0, 32'h0);
    prb(32'h0, 64'h0_0010_0000, 32'h0, 3'h2);
    prb(32'h0, 64'h1_0010_0000, 32'h0, 3'h0);
    wrc(12'h070, 32'h2010);
    rdc(12'h070, 32'h2010);
    wrc(12'h0C8, 32'h5);
    rdc(12'h0C8, 32'h0);
    rdc(12'h0C0, 32'h0);
    wrc(12'h090, 32'h0011);
    rdc(12'h098, 32'h0021);
    $display("wide flags done");
  endtask

  // reset for five cycles, then the scenarios
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {np_addr, io_addr} = 64'h0;
    pf_addr = 64'h0;
    {err_total, comparisons} = 64'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_rsv();
    t_win();
    t_cap();
    stop_test();
  end
endmodule

`default_nettype wire
